// ==== include/dfb_pkg.sv ====
// shared constants for the serial configuration link
package dfb_pkg;
  localparam logic [7:0] DFB_ADDR_WR = 8'h00_DC;
  localparam logic [7:0] DFB_ADDR_RD = 8'h00_DD;
  localparam int DFB_CMD_BYTE_BIT = 7;
  localparam logic [7:0] DFB_CMD_BLOCK = 8'h00_00;
  localparam int DFB_NREG = 3;
  localparam logic [6:0] DFB_NREG7 = 7'h03;
  localparam logic [7:0] DFB_NREG8 = 8'h03;
  localparam logic [7:0] DFB_REG0_RST = 8'h00_07;
  localparam logic [7:0] DFB_REG1_RST = 8'h00_FF;
  localparam logic [7:0] DFB_REG2_RST = 8'h00_00;
  // control register 0 bits
  localparam int DFB_R0_BW = 2;
  localparam int DFB_R0_PLL = 1;
  localparam int DFB_R0_DIV = 0;
  // control register 1 enable bits
  localparam int DFB_R1_OE1 = 1;
  localparam int DFB_R1_OE2 = 2;
  localparam int DFB_R1_OE5 = 5;
  localparam int DFB_R1_OE6 = 6;
  // host side: length of each of the four phases of a serial clock bit in system cycles
  // short phases keep a full block read well inside the bench run time
  localparam int DFB_SCL_HALF_NS = 200;
  localparam int DFB_CLK_NS = 10;
  localparam int DFB_SCL_HALF = DFB_SCL_HALF_NS / DFB_CLK_NS;
  localparam logic [15:0] DFB_SCL_HALF16 = 16'(DFB_SCL_HALF);
  // host command codes
  localparam logic [1:0] DFB_OP_BYTE_WR = 2'h0;
  localparam logic [1:0] DFB_OP_BYTE_RD = 2'h1;
  localparam logic [1:0] DFB_OP_BLK_WR = 2'h2;
  localparam logic [1:0] DFB_OP_BLK_RD = 2'h3;
endpackage

// ==== include/dfb_link_if.sv ====
// two-wire serial link between host controller and buffer
`timescale 1ns/100ps
`default_nettype none
interface dfb_link_if;
  logic scl;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda;
  // open drain: any enabled low driver wins
  assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));
  modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host (output scl, input sda, output sda_host_o, output sda_host_oe);
endinterface
`default_nettype wire

// ==== core/dfb_host.sv ====
// host controller end: drives serial clock and runs byte and block transfers
`timescale 1ns/100ps
`default_nettype none
module dfb_host
  import dfb_pkg::*;
(
  // clock and control
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  // link
  dfb_link_if.host link,
  // command port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata
);
  // regs: 0 cmd go {op}, 1 offset, 2 count, 3 status{busy,nack}, 4.. buffer 0..DFB_NREG-1
  typedef enum logic [3:0] {
    H_IDLE = 4'b0000, H_START = 4'b0001, H_BYTE = 4'b0010, H_ACK = 4'b0011,
    H_RSTART = 4'b0100, H_STOP = 4'b0101, H_DONE = 4'b0110
  } dfb_hst_t;
  typedef struct packed {
    dfb_hst_t st;
    logic [15:0] div;
    logic [1:0] ph;
    logic scl;
    logic sda;
    logic [1:0] op;
    logic [6:0] ofs;
    logic [7:0] cnt;
    logic [7:0] sh;
    logic [2:0] bit_i;
    logic [3:0] step;
    logic [7:0] idx;
    logic rdmode;
    logic busy;
    logic nack;
    logic [DFB_NREG*8-1:0] buf_q;
    logic [7:0] rdata;
    logic s1;
    logic s2;
  } dfb_hs_t;
  dfb_hs_t q, n;
  logic tick;
  logic last_byte;
  always_comb begin
    n = q;
    n.s1 = link.sda;
    n.s2 = q.s1;
    tick = (q.div == DFB_SCL_HALF16);
    n.div = tick ? 16'h0000 : q.div + 16'h0001;
    n.rdata = 8'h00;
    if (rd) begin
      case (addr)
        4'h0: n.rdata = {6'h00, q.op};
        4'h1: n.rdata = {1'b0, q.ofs};
        4'h2: n.rdata = q.cnt;
        4'h3: n.rdata = {6'h00, q.busy, q.nack};
        default: if (addr >= 4'h4 && addr < 4'h4 + 4'(DFB_NREG)) n.rdata = q.buf_q[(addr - 4'h4) * 8 +: 8];
      endcase
    end
    if (wr && !q.busy) begin
      case (addr)
        4'h0: begin
          n.op = wdata[1:0];
          n.busy = 1'b1;
          n.nack = 1'b0;
          n.st = H_START;
          n.ph = 2'h0;
          n.step = 4'h0;
          n.idx = 8'h00;
          n.rdmode = 1'b0;
        end
        4'h1: n.ofs = wdata[6:0];
        4'h2: n.cnt = wdata;
        default: if (addr >= 4'h4 && addr < 4'h4 + 4'(DFB_NREG)) n.buf_q[(addr - 4'h4) * 8 +: 8] = wdata;
      endcase
    end
    // block read: the last data byte is the one whose index plus one reaches the count
    last_byte = (q.op[1] ? (q.step != 4'h3 && q.idx + 8'h01 >= q.cnt) : 1'b1);
    if (tick) begin
      n.ph = q.ph + 2'h1;
      case (q.st)
        H_START, H_RSTART: begin
          // sda falls while scl high
          case (q.ph)
            2'h0: begin n.sda = 1'b1; n.scl = 1'b1; end
            2'h1: n.sda = 1'b0;
            2'h2: n.scl = 1'b0;
            default: begin
              n.ph = 2'h0;
              n.bit_i = 3'h7;
              n.st = H_BYTE;
              n.sh = q.rdmode ? DFB_ADDR_RD : DFB_ADDR_WR;
            end
          endcase
        end
        H_BYTE: begin
          case (q.ph)
            2'h0: n.sda = q.rdmode && q.step > 4'h2 ? 1'b1 : q.sh[7];
            2'h1: n.scl = 1'b1;
            2'h2: begin
              n.scl = 1'b0;
              n.sh = {q.sh[6:0], q.s2};
            end
            default: begin
              n.ph = 2'h0;
              n.bit_i = q.bit_i - 3'h1;
              if (q.bit_i == 3'h0) n.st = H_ACK;
            end
          endcase
        end
        H_ACK: begin
          case (q.ph)
            // host acks read data, last byte gets no ack
            2'h0: n.sda = (q.rdmode && q.step > 4'h2) ? last_byte : 1'b1;
            2'h1: n.scl = 1'b1;
            2'h2: begin
              n.scl = 1'b0;
              if (!(q.rdmode && q.step > 4'h2) && q.s2) n.nack = 1'b1;
            end
            default: begin
              n.ph = 2'h0;
              n.bit_i = 3'h7;
              n.step = q.step + 4'h1;
              n.st = H_BYTE;
              if (q.nack) n.st = H_STOP;
              else if (q.step == 4'h0) n.sh = q.op[1] ? DFB_CMD_BLOCK : {1'b1, q.ofs};
              else if (q.step == 4'h1 && q.op[0]) begin
                n.rdmode = 1'b1;
                n.st = H_RSTART;
              end else if (q.rdmode && q.step == 4'h2) begin
                // read address acked: the next byte comes from the slave
                n.st = H_BYTE;
              end else if (q.rdmode && q.step > 4'h2) begin
                if (q.op[1] && q.step == 4'h3) n.cnt = q.sh;
                else begin
                  if (q.idx < DFB_NREG8) n.buf_q[q.idx[1:0] * 8 +: 8] = q.sh;
                  n.idx = q.idx + 8'h01;
                end
                if ((q.op[1] && q.step != 4'h3 && q.idx + 8'h01 >= q.cnt) || !q.op[1]) n.st = H_STOP;
              end else if (q.step == 4'h1 && q.op[1]) n.sh = q.cnt;
              else if (q.step == 4'h1 || (q.op[1] && q.step > 4'h1 && q.idx < q.cnt)) begin
                n.sh = q.idx < DFB_NREG8 ? q.buf_q[q.idx[1:0] * 8 +: 8] : 8'h00;
                n.idx = q.idx + 8'h01;
              end else n.st = H_STOP;
            end
          endcase
        end
        H_STOP: begin
          case (q.ph)
            2'h0: n.sda = 1'b0;
            2'h1: n.scl = 1'b1;
            2'h2: n.sda = 1'b1;
            default: n.st = H_DONE;
          endcase
        end
        H_DONE: begin
          n.busy = 1'b0;
          n.st = H_IDLE;
        end
        default: n.ph = 2'h0;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      q <= '0;
      q.st <= H_IDLE;
      q.scl <= 1'b1;
      q.sda <= 1'b1;
      q.s1 <= 1'b1;
      q.s2 <= 1'b1;
    end else if (ce) begin
      q <= n;
    end
  end
  assign link.scl = q.scl;
  assign link.sda_host_o = 1'b0;
  assign link.sda_host_oe = !q.sda;
  assign rdata = q.rdata;
endmodule
`default_nettype wire

// ==== core/dfb_device.sv ====
// buffer end: serial configuration slave and output pin control
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - enable pins active high unless strap set
// - power-down active low unless strap set
// - stop request gates stoppable outputs, strap polarity
// - bandwidth pin 0 high, 1 low
// - loop select picks PLL or fan-out
// - configuration loads defaults at reset
// - byte and block read and write
// - block bytes ascend, MSB first, early stop
// - respond only to address DCh
// - command bit 7 selects byte or block
// - command bits 6:0 give byte offset
// - host sends zero command for block
// - block write with count, all acked
// - block read returns count then bytes
// - command 100xxxxx selects single byte
// - byte read returns one byte
module dfb_device
  import dfb_pkg::*;
(
  // clock and control
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  // link
  dfb_link_if.device link,
  // pins
  input wire logic enable_polarity_strap,
  input wire logic oe1_pin,
  input wire logic oe6_pin,
  input wire logic power_down_pin,
  input wire logic stop_request_pin,
  input wire logic bandwidth_select_pin,
  input wire logic loop_select_pin,
  // clock path controls
  output logic [3:0] output_enable,
  output logic power_down,
  output logic stop_active,
  output logic high_bandwidth,
  output logic pll_mode,
  output logic divide_by_two
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_RX = 3'b001, S_ACK = 3'b010, S_TX = 3'b011, S_TXACK = 3'b100, S_IGN = 3'b101
  } dfb_dst_t;
  typedef struct packed {
    logic [6:0] p1;
    logic [6:0] p2;
    logic scl1, scl2, scl3;
    logic sda1, sda2, sda3;
    dfb_dst_t st;
    logic [7:0] sh;
    logic [3:0] bit_i;
    logic [3:0] step;
    logic blk;
    logic rdir;
    logic [6:0] ofs;
    logic [7:0] cnt;
    logic drive;
    logic [7:0] r0, r1, r2;
    logic [3:0] oe;
    logic pd, stp, hbw, pll, div2;
  } dfb_ds_t;
  dfb_ds_t q, n;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic [7:0] rdbyte;
  logic [3:0] pin_oe;
  logic inv;
  always_comb begin
    n = q;
    n.p1 = {enable_polarity_strap, oe1_pin, oe6_pin, power_down_pin, stop_request_pin,
            bandwidth_select_pin, loop_select_pin};
    n.p2 = q.p1;
    n.scl1 = link.scl;
    n.scl2 = q.scl1;
    n.scl3 = q.scl2;
    n.sda1 = link.sda;
    n.sda2 = q.sda1;
    n.sda3 = q.sda2;
    scl_rise = q.scl2 && !q.scl3;
    scl_fall = !q.scl2 && q.scl3;
    start_c = q.scl2 && q.scl3 && q.sda3 && !q.sda2;
    stop_c = q.scl2 && q.scl3 && !q.sda3 && q.sda2;
    case (q.ofs)
      7'h00: rdbyte = q.r0;
      7'h01: rdbyte = q.r1;
      7'h02: rdbyte = q.r2;
      default: rdbyte = 8'h00;
    endcase
    // count goes out first; step only reaches 4 once the count is acked
    if (q.blk && q.step < 4'h4) rdbyte = DFB_NREG8;
    if (start_c) begin
      n.st = S_RX;
      n.bit_i = 4'h0;
      n.step = 4'h0;
      n.drive = 1'b0;
    end else if (stop_c) begin
      n.st = S_IDLE;
      n.drive = 1'b0;
    end else begin
      case (q.st)
        S_RX: if (scl_rise) begin
          n.sh = {q.sh[6:0], q.sda2};
          n.bit_i = q.bit_i + 4'h1;
        end else if (scl_fall && q.bit_i == 4'h8) begin
          n.bit_i = 4'h0;
          n.st = S_ACK;
          n.drive = 1'b1;
          if (q.step == 4'h0 && q.sh != DFB_ADDR_WR && !(q.sh == DFB_ADDR_RD && q.rdir)) begin
            n.st = S_IGN;
            n.drive = 1'b0;
          end else if (q.step == 4'h0 && q.sh == DFB_ADDR_RD) begin
            n.step = 4'h2;
          end else if (q.step == 4'h1) begin
            n.blk = !q.sh[DFB_CMD_BYTE_BIT];
            n.ofs = q.sh[DFB_CMD_BYTE_BIT] ? q.sh[6:0] : 7'h00;
            n.rdir = 1'b1;
          end else if (q.step == 4'h2 && q.blk) begin
            n.cnt = q.sh;
          end else if (q.step >= 4'h2) begin
            case (q.ofs)
              7'h00: n.r0 = q.sh;
              7'h01: n.r1 = q.sh;
              7'h02: n.r2 = q.sh;
              default: n.r2 = q.r2;
            endcase
            if (q.blk) n.ofs = q.ofs + 7'h01;
          end
        end
        S_ACK: if (scl_fall) begin
          n.drive = 1'b0;
          n.bit_i = 4'h0;
          if (q.step == 4'h2 && q.rdir && q.sh == DFB_ADDR_RD) begin
            n.step = 4'h3;
            n.st = S_TX;
            n.drive = !rdbyte[7];
            n.sh = rdbyte;
          end else begin
            if (q.step < 4'h3) n.step = q.step + 4'h1;
            n.st = S_RX;
          end
        end
        S_TX: if (scl_fall) begin
          n.bit_i = q.bit_i + 4'h1;
          n.sh = {q.sh[6:0], 1'b0};
          n.drive = (q.bit_i == 4'h7) ? 1'b0 : !q.sh[6];
          if (q.bit_i == 4'h7) n.st = S_TXACK;
        end
        S_TXACK: if (scl_rise) begin
          if (q.sda2) n.st = S_IGN;
          else begin
            if (q.blk && q.step == 4'h3) n.step = 4'h4;
            else n.ofs = q.ofs + 7'h01;
          end
        end else if (scl_fall) begin
          n.st = S_TX;
          n.bit_i = 4'h0;
          n.sh = rdbyte;
          n.drive = !rdbyte[7];
        end
        default: n.drive = 1'b0;
      endcase
    end
    // pin decode, strap polarity
    inv = q.p2[6];
    pin_oe = {q.p2[4] ^ inv, 1'b1, 1'b1, q.p2[5] ^ inv};
    n.pd = q.p2[3] ^ !inv;
    n.stp = q.p2[2] ^ !inv;
    for (int i = 0; i < 4; i++) begin
      n.oe[i] = pin_oe[i] & q.r1[i < 2 ? i + DFB_R1_OE1 : i + 3] & !n.stp & !n.pd;
    end
    n.hbw = !q.p2[1];
    n.pll = q.p2[0] && q.r0[DFB_R0_PLL];
    n.div2 = !q.r0[DFB_R0_DIV];
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      q <= '0;
      q.st <= S_IDLE;
      q.scl1 <= 1'b1;
      q.scl2 <= 1'b1;
      q.scl3 <= 1'b1;
      q.sda1 <= 1'b1;
      q.sda2 <= 1'b1;
      q.sda3 <= 1'b1;
      q.r0 <= DFB_REG0_RST;
      q.r1 <= DFB_REG1_RST;
      q.r2 <= DFB_REG2_RST;
    end else if (ce) begin
      q <= n;
    end
  end
  assign link.sda_dev_o = 1'b0;
  assign link.sda_dev_oe = q.drive;
  assign output_enable = q.oe;
  assign power_down = q.pd;
  assign stop_active = q.stp;
  assign high_bandwidth = q.hbw;
  assign pll_mode = q.pll;
  assign divide_by_two = q.div2;
endmodule
`default_nettype wire

// ==== verification/dfb_link_asserts.sv ====
// protocol assertions on the serial configuration link
`timescale 1ns/100ps
`default_nettype none
module dfb_link_asserts
  import dfb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // link signals
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe
);
  logic scl_q, sda_q, first_byte, rw, rise, start;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  assign rise = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  // bit position within the byte, restarted by every start condition
  always_ff @(posedge clock) begin
    scl_q <= scl;
    sda_q <= sda;
    if (!rstn) begin
      bit_cnt <= 4'h0;
      first_byte <= 1'b0;
      rw <= 1'b0;
      shift <= 8'h00;
    end else if (start) begin
      bit_cnt <= 4'h0;
      first_byte <= 1'b1;
    end else if (rise) begin
      shift <= {shift[6:0], sda};
      bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
      if (bit_cnt == 4'h8)
        first_byte <= 1'b0;
      if (bit_cnt == 4'h8 && first_byte)
        rw <= shift[0];
      // host nack ends the read phase, the stop that follows is host driven
      if (bit_cnt == 4'h8 && !first_byte && rw && sda)
        rw <= 1'b0;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_dev_od;
    sda_dev_oe |-> !sda_dev_o;
  endproperty
  a_dev_od: assert property (p_dev_od) else $error("device drives data line high");
  property p_host_od;
    sda_host_oe |-> !sda_host_o;
  endproperty
  a_host_od: assert property (p_host_od) else $error("host drives data line high");
  property p_reset_idle;
    $rose(rstn) |-> !sda_dev_oe [*4];
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("device drives after reset");
  property p_dev_scl_low;
    $changed(sda_dev_oe) |-> !scl;
  endproperty
  a_dev_scl_low: assert property (p_dev_scl_low) else $error("device data changed with clock high");
  property p_addr_quiet;
    first_byte && bit_cnt < 4'h8 |-> !sda_dev_oe;
  endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("device drove during address");
  property p_addr_ack;
    rise && first_byte && bit_cnt == 4'h8 |-> sda_dev_oe == (shift[7:1] == DFB_ADDR_WR[7:1]);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address acknowledge wrong");
  property p_write_ack;
    rise && !first_byte && bit_cnt == 4'h8 && !rw |-> sda_dev_oe;
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("written byte not acknowledged");
  property p_read_host_quiet;
    rise && rw && !first_byte && bit_cnt < 4'h8 |-> !sda_host_oe;
  endproperty
  a_read_host_quiet: assert property (p_read_host_quiet) else $error("host drove read data bit");
  property p_read_release;
    rise && rw && !first_byte && bit_cnt == 4'h8 |-> !sda_dev_oe;
  endproperty
  a_read_release: assert property (p_read_release) else $error("device held host ack slot");
endmodule
`default_nettype wire

// ==== verification/smbus_config_slave_and_output_control_tb.sv ====
// bench: host and device over the link, plus a bit-banged second link
`timescale 1ns/100ps
`default_nettype none
module smbus_config_slave_and_output_control_tb
  import dfb_pkg::*;
;
  logic clock, rstn, wr, rd, strap, oe_p, pd_p, stp_p, bw_p, pdn, stopa, hbw, pllm, div2;
  logic [3:0] addr, oen;
  logic [7:0] wdata, rdata;
  int n_mismatch = 0;
  int cmp_count = 0;
  dfb_link_if link();
  dfb_link_if link2();
  dfb_host dfb_host_inst (.clock, .rstn, .ce(1'b1), .link(link.host), .addr, .wdata, .wr, .rd, .rdata);
  dfb_device dfb_device_inst (.clock, .rstn, .ce(1'b1), .link(link.device), .enable_polarity_strap(strap),
    .oe1_pin(oe_p), .oe6_pin(oe_p), .power_down_pin(pd_p), .stop_request_pin(stp_p),
    .bandwidth_select_pin(bw_p), .loop_select_pin(!bw_p), .output_enable(oen), .power_down(pdn),
    .stop_active(stopa), .high_bandwidth(hbw), .pll_mode(pllm), .divide_by_two(div2));
  // second device faces the bench directly so rule breaks can be injected
  dfb_device dfb_device_inst2 (.clock, .rstn, .ce(1'b1), .link(link2.device), .enable_polarity_strap(strap),
    .oe1_pin(oe_p), .oe6_pin(oe_p), .power_down_pin(pd_p), .stop_request_pin(stp_p),
    .bandwidth_select_pin(bw_p), .loop_select_pin(!bw_p), .output_enable(), .power_down(),
    .stop_active(), .high_bandwidth(), .pll_mode(), .divide_by_two());
  dfb_link_asserts dfb_link_asserts_inst (.clock, .rstn, .scl(link.scl), .sda(link.sda),
    .sda_host_o(link.sda_host_o), .sda_host_oe(link.sda_host_oe), .sda_dev_o(link.sda_dev_o),
    .sda_dev_oe(link.sda_dev_oe));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    d = rdata;
  endtask
  // start an operation and poll busy; a hung transfer leaves busy set
  task automatic run_op(input logic [1:0] op);
    logic [7:0] s;
    int n;
    bus_wr(4'h0, {6'h00, op});
    n = 0;
    do begin
      bus_rd(4'h3, s);
      n++;
    end while (s[1] !== 1'b0 && n < 30000);
    chk("status", 8'h00, {6'h00, s[1:0]});
  endtask
  task automatic scn_pins(input logic [7:0] r1);
    logic oea, off;
    logic [3:0] eo;
    for (int i = 0; i < 32; i++) begin
      strap <= i[0];
      oe_p <= i[1];
      pd_p <= i[2];
      stp_p <= i[3];
      bw_p <= i[4];
      repeat (6) @(posedge clock);
      oea = oe_p ^ strap;
      off = !(pd_p ^ strap) || !(stp_p ^ strap);
      eo = {oea & r1[DFB_R1_OE6], r1[DFB_R1_OE5], r1[DFB_R1_OE2], oea & r1[DFB_R1_OE1]} & {4{!off}};
      chk("output_enable", {4'h0, eo}, {4'h0, oen});
      chk("power_down", {7'h00, !(pd_p ^ strap)}, {7'h00, pdn});
      chk("stop_active", {7'h00, !(stp_p ^ strap)}, {7'h00, stopa});
      chk("high_bandwidth", {7'h00, !bw_p}, {7'h00, hbw});
      chk("pll_mode", {7'h00, !bw_p}, {7'h00, pllm});
    end
  endtask
  // second link runs at 160 ns per bit, still between frames
  task automatic bang_bit(input logic b, output logic seen);
    link2.sda_host_oe <= !b;
    repeat (4) @(posedge clock);
    link2.scl <= 1'b1;
    repeat (4) @(posedge clock);
    seen = link2.sda;
    repeat (4) @(posedge clock);
    link2.scl <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic bang_byte(input logic [7:0] b, input logic exp_ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bang_bit(b[i], s);
    bang_bit(1'b1, s);
    chk("link2 ack", {7'h00, exp_ack}, {7'h00, s});
  endtask
  task automatic bang_start;
    link2.sda_host_oe <= 1'b0;
    repeat (4) @(posedge clock);
    link2.scl <= 1'b1;
    repeat (8) @(posedge clock);
    link2.sda_host_oe <= 1'b1;
    repeat (8) @(posedge clock);
    link2.scl <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic scn_foreign;
    bang_start;
    bang_byte(8'hBA, 1'b1);
    bang_byte(DFB_ADDR_WR, 1'b1);
    bang_start;
    bang_byte(DFB_ADDR_WR, 1'b0);
    link2.sda_host_oe <= 1'b1;
    repeat (4) @(posedge clock);
    link2.scl <= 1'b1;
    repeat (8) @(posedge clock);
    link2.sda_host_oe <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
  task automatic scn_byte;
    logic [7:0] d;
    bus_wr(4'h1, 8'h02);
    bus_wr(4'h4, 8'h5A);
    run_op(DFB_OP_BYTE_WR);
    bus_wr(4'h4, 8'h00);
    run_op(DFB_OP_BYTE_RD);
    bus_rd(4'h4, d);
    chk("byte read", 8'h5A, d);
  endtask
  // block write stops after two bytes, so the third register keeps its value
  task automatic scn_block;
    logic [7:0] d;
    logic [7:0] exp [3] = '{8'h06, 8'hDB, 8'h5A};
    bus_wr(4'h2, 8'h02);
    bus_wr(4'h4, 8'h06);
    bus_wr(4'h5, 8'hDB);
    run_op(DFB_OP_BLK_WR);
    chk("divide_by_two", 8'h01, {7'h00, div2});
    bus_wr(4'h2, DFB_NREG8);
    for (int k = 0; k < 3; k++)
      bus_wr(4'h4 + 4'(k), 8'h00);
    run_op(DFB_OP_BLK_RD);
    for (int k = 0; k < 3; k++) begin
      bus_rd(4'h4 + 4'(k), d);
      chk("block read", exp[k], d);
    end
  endtask
  initial begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    strap = 1'b0;
    oe_p = 1'b1;
    pd_p = 1'b1;
    stp_p = 1'b1;
    bw_p = 1'b0;
    link2.scl = 1'b1;
    link2.sda_host_o = 1'b0;
    link2.sda_host_oe = 1'b0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    chk("divide_by_two", 8'h00, {7'h00, div2});
    scn_pins(DFB_REG1_RST);
    scn_foreign;
    scn_byte;
    scn_block;
    scn_pins(8'hDB);
    report_and_stop;
  end
  // whole run needs roughly 16k cycles
  initial begin
    repeat (40000) @(posedge clock);
    n_mismatch++;
    report_and_stop;
  end
endmodule
`default_nettype wire
